// ### core/pdb_pkg.sv
package pdb_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] REG_TENBASE_IDX  = 8'h1a;
	localparam logic [7:0] REG_ERRGAP_IDX   = 8'h1b;
	localparam logic [7:0] REG_PKTLEN_IDX   = 8'h1c;
	localparam logic [7:0] REG_DIAG_IDX     = 8'h1e;
	localparam logic [7:0] REG_IRQ_STAT_IDX = 8'h20;
	localparam logic [7:0] REG_IRQ_MASK_IDX = 8'h21;

	// tenbase_status_control fields
	localparam int TB_LOWTH_BIT   = 13;
	localparam int TB_SQ_LSB      = 9;
	localparam int TB_SQ_MSB      = 12;
	localparam int TB_NLPDIS_BIT  = 7;
	localparam int TB_POL_BIT     = 4;
	localparam int TB_JABDIS_BIT  = 0;
	localparam logic [3:0] TB_SQ_RESET = 4'h0;
	// 200 mV + 8 * 50 mV = 600 mV
	localparam logic [3:0] TB_SQ_MAX   = 4'h8;

	// selftest_errcount_gap fields
	localparam int EG_SNAP_BIT = 15;
	localparam int EG_CNT_LSB  = 8;
	localparam int EG_CNT_MSB  = 15;
	localparam int EG_IPG_MSB  = 7;
	localparam logic [7:0] EG_IPG_RESET = 8'h7d;

	// selftest_packet_length fields
	localparam int PL_LEN_MSB = 10;
	localparam logic [10:0] PL_LEN_RESET = 11'h5dc;

	// cable_diag_control fields
	localparam int CD_START_BIT = 15;
	localparam int CD_LQ_LSB    = 8;
	localparam int CD_LQ_MSB    = 9;
	localparam int CD_DONE_BIT  = 1;
	localparam int CD_FAIL_BIT  = 0;

	// Interrupt status and mask bits
	localparam int IRQ_W          = 4;
	localparam int IRQ_DONE_BIT   = 0;
	localparam int IRQ_FAIL_BIT   = 1;
	localparam int IRQ_POL_BIT    = 2;
	localparam int IRQ_ERRSAT_BIT = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	localparam int ERR_W = 8;
	localparam logic [ERR_W-1:0] ERR_MAX = 8'hff;

	typedef enum logic [1:0] {
		PDB_LQ_RSVD,
		PDB_LQ_GOOD,
		PDB_LQ_MID,
		PDB_LQ_POOR
	} pdb_lq_t;

	typedef struct packed {
		logic       low_thresh;
		logic [3:0] squelch;
		logic       nlp_disable;
		logic       jabber_disable;
	} pdb_tenbase_cfg_t;

	typedef struct packed {
		logic [7:0]  ipg_bytes;
		logic [10:0] pkt_len;
	} pdb_selftest_cfg_t;

	typedef struct packed {
		logic    done;
		logic    fail;
		pdb_lq_t quality;
	} pdb_diag_res_t;

endpackage

// ### core/pdb_err_counter.sv
`timescale 1ns/1ps
`default_nettype none

module pdb_err_counter
	import pdb_pkg::*;
#(
	parameter int W = ERR_W
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic         err_byte,
	input  wire logic         count_wrap,
	input  wire logic         freeze,
	input  wire logic         snap,
	input  wire logic         release_hold,
	output logic [W-1:0]      count_shown,
	output logic              saturated
);

	initial begin
		if (W < 1 || W > 8) begin
			$error("pdb_err_counter: W must be 1..8");
		end
	end

	localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

	logic [W-1:0] running;
	logic         hold;
	logic         at_max;
	logic [W-1:0] next_running;
	logic         next_hold;

	assign at_max = (running == CNT_MAX);
	assign saturated = err_byte && at_max && !count_wrap && !snap;

	// Saturate unless wrap mode is selected
	always_comb begin
		next_running = running;
		if (snap) begin
			next_running = '0;
		end else if (err_byte && (count_wrap || !at_max)) begin
			next_running = running + 1'b1;
		end
	end

	// Hold keeps the shown value still for successive reads
	always_comb begin
		next_hold = hold;
		if (snap || freeze) begin
			next_hold = 1'b1;
		end else if (release_hold) begin
			next_hold = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			running     <= '0;
			hold        <= 1'b0;
			count_shown <= '0;
		end else begin
			running <= next_running;
			hold    <= next_hold;
			if (snap) begin
				count_shown <= running;
			end else if (!hold && !freeze) begin
				count_shown <= next_running;
			end
		end
	end

endmodule // pdb_err_counter

`default_nettype wire

// ### core/pdb_regs.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - reserved bits ignore writes, read zero
// - bit 13 selects lower receive threshold
// - bits 12:9 squelch, 50mV steps, 200mV reset
// - bit 7 stops normal link pulses
// - bit 4 reports inverted receive polarity
// - polarity mirrored; control read clears both
// - bit 0 disables jabber in 10Mb
// - bits 15:8 count erroneous self-test bytes
// - count saturates at 0xFF in mode zero
// - writing bit 15 latches, clears counter
// - bits 7:0 packet gap, reset 0x7D
// - bits 10:0 packet length, reset 0x5DC
// - bit 15 starts diagnostics, cleared at done
// - bits 9:8 link quality code
// - bit 1 reads done after measurement
// - bit 0 reads failed measurement
module pdb_regs
	import pdb_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// 10 Mb/s receiver side
	input  wire logic              pol_inverted,
	output pdb_tenbase_cfg_t       tenbase_cfg,
	output logic                   phy_status_polarity,
	// Self-test generator and checker side
	input  wire logic              prbs_err_byte,
	input  wire logic              prbs_count_wrap,
	input  wire logic              selftest_ctrl_wr01,
	output pdb_selftest_cfg_t      selftest_cfg,
	// Cable diagnostic engine side
	input  wire pdb_diag_res_t     diag_result,
	output logic                   diag_start,
	// Interrupt
	output logic                   irq
);

	// Upper address bits are compared, so at least one must lie above the index
	initial begin
		if (ADDR_W < 11 || ADDR_W > 32) begin
			$error("pdb_regs: ADDR_W must be 11..32");
		end
		if (ERR_W != EG_CNT_MSB - EG_CNT_LSB + 1) begin
			$error("pdb_regs: error count must fill its field");
		end
		if (IRQ_W > 32) begin
			$error("pdb_regs: interrupt bits must fit one word");
		end
	end

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;

	// Address phase capture
	// Write data lags its address by a cycle, so the address is kept
	logic              dp_valid;
	logic              dp_write;
	logic [7:0]        dp_idx;
	logic              dp_word;

	wire               ap_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	wire  [7:0]        ap_idx  = haddr[9:2];
	wire               ap_word = (haddr[ADDR_W-1:10] == '0) && (haddr[1:0] == 2'b00);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_idx   <= 8'h00;
			dp_word  <= 1'b0;
		end else begin
			dp_valid <= ap_take;
			dp_write <= hwrite;
			dp_idx   <= ap_idx;
			dp_word  <= ap_word;
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Data phase decode
	// Size is not checked; every word-aligned access acts on a whole word
	wire dp_hit     = dp_valid && dp_word;
	wire sel_tb     = dp_hit && (dp_idx == REG_TENBASE_IDX);
	wire sel_eg     = dp_hit && (dp_idx == REG_ERRGAP_IDX);
	wire sel_pl     = dp_hit && (dp_idx == REG_PKTLEN_IDX);
	wire sel_cd     = dp_hit && (dp_idx == REG_DIAG_IDX);
	wire sel_ist    = dp_hit && (dp_idx == REG_IRQ_STAT_IDX);
	wire sel_imk    = dp_hit && (dp_idx == REG_IRQ_MASK_IDX);

	wire wr_tb      = sel_tb  && dp_write;
	wire wr_eg      = sel_eg  && dp_write;
	wire wr_pl      = sel_pl  && dp_write;
	wire wr_cd      = sel_cd  && dp_write;
	wire wr_imk     = sel_imk && dp_write;
	wire rd_tb      = sel_tb  && !dp_write;
	wire rd_ist     = sel_ist && !dp_write;

	// tenbase_status_control
	// Polarity is read-only; a write to bit 4 has no effect
	logic       low_thresh;
	logic [3:0] squelch;
	logic       nlp_disable;
	logic       jabber_disable;
	logic       pol_flag;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			low_thresh     <= 1'b0;
			squelch        <= TB_SQ_RESET;
			nlp_disable    <= 1'b0;
			jabber_disable <= 1'b0;
		end else if (wr_tb) begin
			low_thresh     <= hwdata[TB_LOWTH_BIT];
			squelch        <= hwdata[TB_SQ_MSB:TB_SQ_LSB];
			nlp_disable    <= hwdata[TB_NLPDIS_BIT];
			jabber_disable <= hwdata[TB_JABDIS_BIT];
		end
	end

	// Detection beats the clear of a read in the same cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pol_flag <= 1'b0;
		end else if (pol_inverted) begin
			pol_flag <= 1'b1;
		end else if (rd_tb) begin
			pol_flag <= 1'b0;
		end
	end

	// Squelch codes above 600 mV are held at the top step
	wire [3:0] squelch_eff = (squelch > TB_SQ_MAX) ? TB_SQ_MAX : squelch;

	assign tenbase_cfg = '{
		low_thresh:     low_thresh,
		squelch:        squelch_eff,
		nlp_disable:    nlp_disable,
		jabber_disable: jabber_disable
	};
	// The status-register copy is the same flop, so only control reads clear it
	assign phy_status_polarity        = pol_flag;

	// selftest_errcount_gap and selftest_packet_length
	// Reserved bits of both words are dropped here, never stored
	logic [7:0]       ipg_bytes;
	logic [10:0]      pkt_len;
	logic [ERR_W-1:0] err_shown;
	logic             err_saturated;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ipg_bytes <= EG_IPG_RESET;
			pkt_len   <= PL_LEN_RESET;
		end else begin
			if (wr_eg) begin
				ipg_bytes <= hwdata[EG_IPG_MSB:0];
			end
			if (wr_pl) begin
				pkt_len <= hwdata[PL_LEN_MSB:0];
			end
		end
	end

	assign selftest_cfg = '{
		ipg_bytes: ipg_bytes,
		pkt_len:   pkt_len
	};

	// Any write with bit 15 low ends a hold, so gap writes release it too
	wire snap_wr    = wr_eg && hwdata[EG_SNAP_BIT];
	wire release_wr = wr_eg && !hwdata[EG_SNAP_BIT];

	pdb_err_counter #(
		.W (ERR_W)
	) u_err_counter (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.err_byte     (prbs_err_byte),
		.count_wrap   (prbs_count_wrap),
		.freeze       (selftest_ctrl_wr01),
		.snap         (snap_wr),
		.release_hold (release_wr),
		.count_shown  (err_shown),
		.saturated    (err_saturated)
	);

	// cable_diag_control
	logic    diag_run;
	logic    diag_done;
	logic    diag_fail;
	pdb_lq_t link_quality;

	// Completion beats a same-cycle start write; software restarts afterwards
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			diag_run  <= 1'b0;
			diag_done <= 1'b0;
			diag_fail <= 1'b0;
		end else if (diag_run && diag_result.done) begin
			diag_run  <= 1'b0;
			diag_done <= 1'b1;
			diag_fail <= diag_result.fail;
		end else if (wr_cd) begin
			diag_run <= hwdata[CD_START_BIT];
			if (hwdata[CD_START_BIT]) begin
				diag_done <= 1'b0;
				diag_fail <= 1'b0;
			end
		end
	end

	// Quality is sampled continuously; software checks link status first
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			link_quality <= PDB_LQ_RSVD;
		end else begin
			link_quality <= diag_result.quality;
		end
	end

	assign diag_start = diag_run;

	// Interrupt status and mask
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] next_irq_status;

	// Polarity raises an event on a fresh detection only, not while it persists
	always_comb begin
		irq_event                 = '0;
		irq_event[IRQ_DONE_BIT]   = diag_run && diag_result.done;
		irq_event[IRQ_FAIL_BIT]   = diag_run && diag_result.done && diag_result.fail;
		irq_event[IRQ_POL_BIT]    = pol_inverted && !pol_flag;
		irq_event[IRQ_ERRSAT_BIT] = err_saturated;
	end

	// Read clears, but a new event in the same cycle survives
	assign next_irq_status = (rd_ist ? '0 : irq_status) | irq_event;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_status <= '0;
			irq_mask   <= IRQ_MASK_RESET;
		end else begin
			irq_status <= next_irq_status;
			if (wr_imk) begin
				irq_mask <= hwdata[IRQ_W-1:0];
			end
		end
	end

	// Level output; it drops as soon as software reads the status
	assign irq = |(irq_status & irq_mask);

	// Read-back; unnamed bits stay zero
	logic [15:0] rd_tb_val;
	logic [15:0] rd_eg_val;
	logic [15:0] rd_pl_val;
	logic [15:0] rd_cd_val;

	always_comb begin
		rd_tb_val                        = 16'h0000;
		rd_tb_val[TB_LOWTH_BIT]          = low_thresh;
		rd_tb_val[TB_SQ_MSB:TB_SQ_LSB]   = squelch;
		rd_tb_val[TB_NLPDIS_BIT]         = nlp_disable;
		rd_tb_val[TB_POL_BIT]            = pol_flag;
		rd_tb_val[TB_JABDIS_BIT]         = jabber_disable;
	end

	always_comb begin
		rd_eg_val                        = 16'h0000;
		rd_eg_val[EG_CNT_MSB:EG_CNT_LSB] = err_shown;
		rd_eg_val[EG_IPG_MSB:0]          = ipg_bytes;
	end

	always_comb begin
		rd_pl_val                        = 16'h0000;
		rd_pl_val[PL_LEN_MSB:0]          = pkt_len;
	end

	// Start bit reads back as the request still pending
	always_comb begin
		rd_cd_val                        = 16'h0000;
		rd_cd_val[CD_START_BIT]          = diag_run;
		rd_cd_val[CD_LQ_MSB:CD_LQ_LSB]   = link_quality;
		rd_cd_val[CD_DONE_BIT]           = diag_done;
		rd_cd_val[CD_FAIL_BIT]           = diag_fail;
	end

	wire rd_any = dp_hit && !dp_write;

	logic [31:0] rd_word;

	// Data-phase mux of register flops; holds stable for the whole data phase
	always_comb begin
		rd_word = 32'h0000_0000;
		if (!rd_any) begin
			rd_word = 32'h0000_0000;
		end else if (sel_tb) begin
			rd_word = {16'h0000, rd_tb_val};
		end else if (sel_eg) begin
			rd_word = {16'h0000, rd_eg_val};
		end else if (sel_pl) begin
			rd_word = {16'h0000, rd_pl_val};
		end else if (sel_cd) begin
			rd_word = {16'h0000, rd_cd_val};
		end else if (sel_ist) begin
			rd_word = {{(32-IRQ_W){1'b0}}, irq_status};
		end else if (sel_imk) begin
			rd_word = {{(32-IRQ_W){1'b0}}, irq_mask};
		end
	end

	// Unmapped and misaligned reads fall through to zero
	assign hrdata = rd_word;

endmodule // pdb_regs

`default_nettype wire

// ### verif/pdb_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pdb_regs_sva
	import pdb_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input	wire logic	clk_sys,
	input	wire logic	reset,
	input	wire logic	hsel,
	input	wire logic [ADDR_W-1:0]	haddr,
	input	wire logic [1:0]	htrans,
	input	wire logic	hwrite,
	input	wire logic [31:0]	hwdata,
	input	wire logic	hready,
	input	wire logic	hreadyout,
	input	wire logic	hresp,
	input	wire logic [31:0]	hrdata,
	input	wire logic	pol_inverted,
	input	wire pdb_tenbase_cfg_t	tenbase_cfg,
	input	wire logic	phy_status_polarity,
	input	wire pdb_selftest_cfg_t	selftest_cfg,
	input	wire pdb_diag_res_t	diag_result,
	input	wire logic	diag_start
);
	// Data phase tracking, mirrors the bus timing
	logic	ph_w;
	logic	ph_r;
	logic [ADDR_W-1:0]	ph_a;
	wire logic	take = hsel & hready & htrans[1];
	wire logic	hit_tb = ph_a == ADDR_W'(12'h068);
	wire logic	hit_eg = ph_a == ADDR_W'(12'h06c);
	wire logic	hit_pl = ph_a == ADDR_W'(12'h070);
	wire logic	hit_cd = ph_a == ADDR_W'(12'h078);
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ph_w <= 1'b0;
			ph_r <= 1'b0;
			ph_a <= '0;
		end else begin
			ph_w <= take & hwrite;
			ph_r <= take & ~hwrite;
			ph_a <= haddr;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	AST_RSVD_ZERO: assert property (ph_r |-> hrdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	AST_IDLE_ZERO: assert property (!ph_r |-> hrdata == 32'h0)
		else $error("read data outside a read");
	AST_TB_WRITE: assert property (ph_w && hit_tb |=>
		tenbase_cfg.low_thresh == $past(hwdata[13]) && tenbase_cfg.nlp_disable == $past(hwdata[7])
		&& tenbase_cfg.jabber_disable == $past(hwdata[0])) else $error("tenbase config wrong");
	AST_SQ_CLAMP: assert property (ph_w && hit_tb |=> tenbase_cfg.squelch ==
		($past(hwdata[12:9]) > TB_SQ_MAX ? TB_SQ_MAX : $past(hwdata[12:9])))
		else $error("squelch wrong");
	AST_IPG: assert property (ph_w && hit_eg |=> selftest_cfg.ipg_bytes == $past(hwdata[7:0]))
		else $error("gap wrong");
	AST_PKTLEN: assert property (ph_w && hit_pl |=> selftest_cfg.pkt_len == $past(hwdata[10:0]))
		else $error("length wrong");
	AST_POL_SET: assert property (pol_inverted |=> phy_status_polarity)
		else $error("polarity not flagged");
	AST_POL_CLR: assert property (ph_r && hit_tb && !pol_inverted |=> !phy_status_polarity)
		else $error("polarity not cleared");
	AST_POL_HOLD: assert property (phy_status_polarity && !(ph_r && hit_tb) |=> phy_status_polarity)
		else $error("polarity lost");
	AST_DONE_STOP: assert property (diag_start && diag_result.done |=> !diag_start)
		else $error("start not cleared");
	AST_START: assert property (ph_w && hit_cd && hwdata[15] && !diag_result.done |=> diag_start)
		else $error("start not set");
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("response not zero-wait OKAY");
endmodule // pdb_regs_sva
bind pdb_regs pdb_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// ### verif/test_phy_diag_bist_10bt_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_phy_diag_bist_10bt_regs
	import pdb_pkg::*;
;
	logic	clk_sys = 1'b0;
	logic	reset = 1'b1;
	logic	hsel = 1'b0;
	logic [11:0]	haddr = '0;
	logic [1:0]	htrans = '0;
	logic	hwrite = 1'b0;
	logic [2:0]	hsize = 3'h2;
	logic [31:0]	hwdata = '0;
	logic	hready;
	logic	hreadyout;
	logic	hresp;
	logic [31:0]	hrdata;
	logic	pol_inverted = 1'b0;
	pdb_tenbase_cfg_t	tenbase_cfg;
	logic	phy_status_polarity;
	logic	prbs_err_byte = 1'b0;
	logic	prbs_count_wrap = 1'b0;
	logic	selftest_ctrl_wr01 = 1'b0;
	pdb_selftest_cfg_t	selftest_cfg;
	pdb_diag_res_t	diag_result = '0;
	logic	diag_start;
	logic	irq;
	logic	dp_rd = 1'b0;
	logic [31:0]	exp_q[$];
	logic [31:0]	r;
	logic [31:0]	tb;
	int	errors = 0;
	int	tests_run = 0;
	assign hready = hreadyout;
	pdb_regs #(.ADDR_W(12)) dut (.*);
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read results are judged in the data phase, away from the edges
	always @(negedge clk_sys) begin
		if (dp_rd) chk(hrdata, exp_q.pop_front());
	end
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		dp_rd <= !w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		dp_rd <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(a, 1'b0, 32'h0);
	endtask
	task automatic errs(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			prbs_err_byte <= 1'b1;
			@(posedge clk_sys);
			prbs_err_byte <= 1'b0;
		end
	endtask
	task automatic fin(input string s);
		$display("Test %s finished", s);
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		$display("Error at %0t: timeout", $time);
		end_of_test();
	end
	initial begin
		void'($urandom(72347));
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		rd(12'h068, 32'h0);
		rd(12'h06c, 32'h7d);
		rd(12'h070, 32'h5dc);
		rd(12'h078, 32'h0);
		@(negedge clk_sys);
		chk({13'h0, selftest_cfg}, {13'h0, EG_IPG_RESET, PL_LEN_RESET});
		fin("reset");
		for (int i = 0; i < 5; i++) begin
			r = (i == 0) ? 32'hffffffff : $urandom;
			tb = r & 32'h3e81;
			wr(12'h068, r);
			rd(12'h068, tb);
			@(negedge clk_sys);
			chk({25'h0, tenbase_cfg}, {25'h0, r[13],
				(r[12:9] > TB_SQ_MAX ? TB_SQ_MAX : r[12:9]), r[7], r[0]});
		end
		r = $urandom;
		wr(12'h070, r);
		rd(12'h070, {21'h0, r[10:0]});
		wr(12'h06c, {24'h0, r[7:0]});
		rd(12'h06c, {24'h0, r[7:0]});
		fin("config");
		wr(12'h084, 32'h4);
		@(posedge clk_sys);
		pol_inverted <= 1'b1;
		@(posedge clk_sys);
		pol_inverted <= 1'b0;
		@(negedge clk_sys);
		chk({30'h0, irq, phy_status_polarity}, 32'h3);
		rd(12'h080, 32'h4);
		rd(12'h068, tb | 32'h10);
		rd(12'h068, tb);
		@(negedge clk_sys);
		chk({30'h0, irq, phy_status_polarity}, 32'h0);
		fin("polarity");
		wr(12'h06c, 32'h807d);
		wr(12'h06c, 32'h7d);
		errs(5);
		rd(12'h06c, 32'h057d);
		@(posedge clk_sys);
		selftest_ctrl_wr01 <= 1'b1;
		@(posedge clk_sys);
		selftest_ctrl_wr01 <= 1'b0;
		errs(3);
		rd(12'h06c, 32'h057d);
		wr(12'h06c, 32'h807d);
		rd(12'h06c, 32'h087d);
		wr(12'h06c, 32'h7d);
		errs(300);
		rd(12'h06c, 32'hff7d);
		rd(12'h080, 32'h8);
		prbs_count_wrap <= 1'b1;
		wr(12'h06c, 32'h807d);
		wr(12'h06c, 32'h7d);
		errs(260);
		rd(12'h06c, 32'h047d);
		fin("error count");
		wr(12'h084, 32'h3);
		for (int q = 1; q < 4; q++) begin
			diag_result.quality <= pdb_lq_t'(q);
			wr(12'h078, 32'h8000);
			rd(12'h078, {16'h0, 1'b1, 5'h0, 2'(q), 8'h0});
			@(posedge clk_sys);
			diag_result <= {1'b1, q[0], 2'(q)};
			@(posedge clk_sys);
			diag_result.done <= 1'b0;
			@(negedge clk_sys);
			chk({30'h0, diag_start, irq}, 32'h1);
			rd(12'h078, {22'h0, 2'(q), 6'h0, 1'b1, q[0]});
		end
		rd(12'h080, 32'h3);
		rd(12'h084, 32'h3);
		@(negedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		fin("diagnostics");
		wr(12'h078, 32'h0303);
		rd(12'h078, 32'h0303);
		wr(12'h07c, 32'hffffffff);
		rd(12'h07c, 32'h0);
		rd(12'h069, 32'h0);
		fin("unmapped");
		end_of_test();
	end
endmodule // test_phy_diag_bist_10bt_regs
`default_nettype wire
